// >>> logic/bsc_defines.svh
// timing counts and reset values for the backplane sideband control block
`ifndef BSC_DEFINES_SVH
`define BSC_DEFINES_SVH

// core clock period, nanoseconds
`define BSC_CLK_PERIOD_NS 100
// settle time a sideband level must hold before it is acted on, nanoseconds
`define BSC_DEBOUNCE_NS 10000
// least time rounds up to whole cycles
`define BSC_DEBOUNCE_CYC ((`BSC_DEBOUNCE_NS + `BSC_CLK_PERIOD_NS - 1) / `BSC_CLK_PERIOD_NS)
// two-wire lines are only resynchronised, one stable sample is enough
`define BSC_LINE_FILTER_CYC 1
// sideband channels per x8 connector
`define BSC_SB_PER_CONN 2
// default number of x8 connectors
`define BSC_NUM_CONN 4

// reset values
`define BSC_RST_MGMT_RESET_N 1'b1
`define BSC_RST_PERST_OE 1'b1
`define BSC_RST_REFCLK_EN 1'b0
`define BSC_RST_PIN_LEVEL 1'b1

`endif

// >>> logic/bsc_pkg.sv
// types shared by the backplane sideband control block
`default_nettype none
package bsc_pkg;

  typedef enum logic [2:0]
  {
    SB_IDLE = 3'b000,
    SB_UNREC = 3'b001,
    SB_WAIT_DRIVE = 3'b010,
    SB_ACTIVE = 3'b011
  } bsc_sb_state_t;

  typedef enum logic
  {
    MP_PRESENCE = 1'b0,
    MP_CHANGE = 1'b1
  } bsc_mp_mode_t;

  // pin levels arriving from the connector, one sideband
  typedef struct packed {
    logic backplane_type_sel;
    logic mp_pin_in;
    logic mgmt_bus_clock_in;
    logic mgmt_bus_data_in;
  } bsc_pin_in_t;

  // pin drive toward the connector, one sideband
  typedef struct packed {
    logic mgmt_bus_reset_n;
    logic perst_n_out;
    logic perst_n_oe;
    logic refclk_en;
    logic mp_pin_out;
    logic mp_pin_oe;
    logic mgmt_bus_clock_out;
    logic mgmt_bus_clock_oe;
    logic mgmt_bus_data_out;
    logic mgmt_bus_data_oe;
  } bsc_pin_out_t;

  // settings from management firmware, one sideband
  typedef struct packed {
    logic target_resettable;
    logic mgmt_reset_req;
    logic clock_routing_cap;
    logic change_detect_n_capable;
    logic mgmt_clock_pull;
    logic mgmt_data_pull;
  } bsc_ctrl_t;

  // state reported to management firmware, one sideband
  typedef struct packed {
    logic unrecognised_bp;
    logic sb_configured;
    logic drive_present;
    logic cable_type;
    logic change_detect_n_mode;
    logic change_detect;
    logic mgmt_clock_level;
    logic mgmt_data_level;
    logic mgmt_clock_rise;
  } bsc_status_t;

endpackage
`default_nettype wire

// >>> logic/bsc_sideband_ctrl.sv
// per-sideband management logic of the storage switch adapter connectors
// ==========================================================================
// Notes on behaviour
// - every x8 connector carries independent sidebands A and B.
// - type select low: sideband left unconfigured, unrecognised backplane reported.
// - management bus reset is active low, only applied to resettable targets.
// - drive present low enables the reference clock of that lane quad.
// - clock routing capability zero forces the reference clock off.
// - PCIe reset held low from power-up until detection allows open-drain release.
// - PCIe reset stays asserted until the attached drive is detected.
// - multipurpose pin is open-drain; either side only pulls low or releases.
// - cable type reads as one when the pin floats high while the pin still means presence.
// - present drive with change-detect capable FRU switches pin to change detect.
// - management clock and data form the bidirectional two-wire bus.
// ==========================================================================
`timescale 1ns/1ns
`default_nettype none
`include "bsc_defines.svh"

module bsc_sideband_ctrl #(
  parameter int NUM_CONN = `BSC_NUM_CONN,
  parameter int DEBOUNCE_CYC = `BSC_DEBOUNCE_CYC,
  localparam int NUM_SB = NUM_CONN * `BSC_SB_PER_CONN
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // connector pins, index 2*c is side A and 2*c+1 side B of connector c
  input wire bsc_pkg::bsc_pin_in_t [NUM_SB-1:0] pin_in,
  output bsc_pkg::bsc_pin_out_t [NUM_SB-1:0] pin_out,
  // firmware side
  input wire bsc_pkg::bsc_ctrl_t [NUM_SB-1:0] ctrl,
  output bsc_pkg::bsc_status_t [NUM_SB-1:0] status
);

  initial
  begin
    if (NUM_CONN < 1)
    begin
      $error("bsc_sideband_ctrl: NUM_CONN must be at least 1");
    end
    if (DEBOUNCE_CYC < 1)
    begin
      $error("bsc_sideband_ctrl: DEBOUNCE_CYC must be at least 1");
    end
  end

  // ========================================================================
  // input synchronisation
  // ========================================================================

  logic [NUM_SB-1:0] type_lvl;
  logic [NUM_SB-1:0] type_vld;
  logic [NUM_SB-1:0] mp_lvl;
  logic [NUM_SB-1:0] mp_vld;
  logic [NUM_SB-1:0] scl_lvl;
  logic [NUM_SB-1:0] sda_lvl;

  genvar gi;
  generate
    for (gi = 0; gi < NUM_SB; gi++)
    begin : g_sb
      bsc_sync_filter #(.STABLE_CYC(DEBOUNCE_CYC)) u_type (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_async(pin_in[gi].backplane_type_sel),
        .level(type_lvl[gi]),
        .valid(type_vld[gi])
      );
      bsc_sync_filter #(.STABLE_CYC(DEBOUNCE_CYC)) u_mp (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_async(pin_in[gi].mp_pin_in),
        .level(mp_lvl[gi]),
        .valid(mp_vld[gi])
      );
      // two-wire lines only need resynchronising
      bsc_sync_filter #(.STABLE_CYC(`BSC_LINE_FILTER_CYC)) u_scl (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_async(pin_in[gi].mgmt_bus_clock_in),
        .level(scl_lvl[gi]),
        .valid()
      );
      bsc_sync_filter #(.STABLE_CYC(`BSC_LINE_FILTER_CYC)) u_sda (
        .ref_clk(ref_clk),
        .reset(reset),
        .pin_async(pin_in[gi].mgmt_bus_data_in),
        .level(sda_lvl[gi]),
        .valid()
      );
    end
  endgenerate

  // ========================================================================
  // state
  // ========================================================================

  typedef struct packed {
    bsc_pkg::bsc_sb_state_t fsm;
    bsc_pkg::bsc_mp_mode_t mode;
    logic present;
    logic perst_oe;
    logic refclk_en;
    logic mgmt_rst_n;
    logic scl_oe;
    logic sda_oe;
    logic mp_prev;
    logic scl_prev;
    logic unrec;
    logic cable_type;
    logic chg_pulse;
    logic scl_level;
    logic sda_level;
    logic scl_rise;
    logic configured;
  } bsc_sb_t;

  typedef struct packed {
    bsc_sb_t [NUM_SB-1:0] sb;
  } bsc_top_state_t;

  bsc_top_state_t st_q;
  bsc_top_state_t st_d;

  // ========================================================================
  // next state
  // ========================================================================

  always_comb
  begin
    st_d = st_q;
    for (int i = 0; i < NUM_SB; i++)
    begin
      st_d.sb[i].mp_prev = mp_lvl[i];
      st_d.sb[i].scl_prev = scl_lvl[i];
      st_d.sb[i].scl_level = scl_lvl[i];
      st_d.sb[i].sda_level = sda_lvl[i];
      st_d.sb[i].scl_rise = scl_lvl[i] && !st_q.sb[i].scl_prev;
      st_d.sb[i].chg_pulse = 1'b0;
      case (st_q.sb[i].fsm)
        bsc_pkg::SB_IDLE:
        begin
          // wait until both filters have seen a settled level
          // type select low
          if (type_vld[i] && mp_vld[i])
          begin
            st_d.sb[i].fsm = type_lvl[i] ? bsc_pkg::SB_WAIT_DRIVE : bsc_pkg::SB_UNREC;
          end
        end
        bsc_pkg::SB_UNREC:
        begin
          // a backplane rejumpered to two-wire is picked up again
          if (type_lvl[i])
          begin
            st_d.sb[i].fsm = bsc_pkg::SB_WAIT_DRIVE;
          end
        end
        bsc_pkg::SB_WAIT_DRIVE:
        begin
          if (!type_lvl[i])
          begin
            st_d.sb[i].fsm = bsc_pkg::SB_UNREC;
          end
          else if (!mp_lvl[i])
          begin
            st_d.sb[i].fsm = bsc_pkg::SB_ACTIVE;
            st_d.sb[i].present = 1'b1;
          end
        end
        bsc_pkg::SB_ACTIVE:
        begin
          if (!type_lvl[i])
          begin
            st_d.sb[i].fsm = bsc_pkg::SB_UNREC;
            st_d.sb[i].present = 1'b0;
            st_d.sb[i].mode = bsc_pkg::MP_PRESENCE;
          end
          // removal is only seen while the pin still means presence
          else if (st_q.sb[i].mode == bsc_pkg::MP_PRESENCE && mp_lvl[i])
          begin
            st_d.sb[i].fsm = bsc_pkg::SB_WAIT_DRIVE;
            st_d.sb[i].present = 1'b0;
          end
        end
        default:
        begin
          st_d.sb[i].fsm = bsc_pkg::SB_IDLE;
        end
      endcase

      // change-detect mode
      // judged on the next state, so leaving the active state hands the
      // pin back to presence use in the same cycle
      if (st_d.sb[i].fsm == bsc_pkg::SB_ACTIVE && st_d.sb[i].present
          && ctrl[i].change_detect_n_capable)
      begin
        st_d.sb[i].mode = bsc_pkg::MP_CHANGE;
      end
      else
      begin
        st_d.sb[i].mode = bsc_pkg::MP_PRESENCE;
      end
      // backplane pulls low
      // only while the mode stood before and still stands, so the falling
      // presence edge at entry is never taken for a change event
      if (st_q.sb[i].mode == bsc_pkg::MP_CHANGE && st_d.sb[i].mode == bsc_pkg::MP_CHANGE
          && st_q.sb[i].mp_prev && !mp_lvl[i])
      begin
        st_d.sb[i].chg_pulse = 1'b1;
      end

      if (st_q.sb[i].mode == bsc_pkg::MP_PRESENCE)
      begin
        st_d.sb[i].cable_type = mp_lvl[i];
      end

      st_d.sb[i].unrec = (st_d.sb[i].fsm == bsc_pkg::SB_UNREC);
      // the configured report has a flop of its own, not a decode at the pin
      st_d.sb[i].configured = (st_d.sb[i].fsm == bsc_pkg::SB_ACTIVE);
      // open-drain release
      // any fall back out of the active state clamps the reset again
      st_d.sb[i].perst_oe = (st_d.sb[i].fsm != bsc_pkg::SB_ACTIVE);
      st_d.sb[i].refclk_en = (st_d.sb[i].fsm == bsc_pkg::SB_ACTIVE)
                             && st_d.sb[i].present && ctrl[i].clock_routing_cap;
      // resettable targets only
      // requests toward an unsupported backplane are dropped
      st_d.sb[i].mgmt_rst_n = !(ctrl[i].mgmt_reset_req && ctrl[i].target_resettable
                                && st_q.sb[i].fsm != bsc_pkg::SB_UNREC);
      // two-wire bus pulls
      // no two-wire traffic toward a backplane that is not two-wire
      st_d.sb[i].scl_oe = ctrl[i].mgmt_clock_pull && st_q.sb[i].fsm != bsc_pkg::SB_UNREC;
      st_d.sb[i].sda_oe = ctrl[i].mgmt_data_pull && st_q.sb[i].fsm != bsc_pkg::SB_UNREC;
    end
  end

  // ========================================================================
  // registers
  // ========================================================================

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      for (int i = 0; i < NUM_SB; i++)
      begin
        st_q.sb[i] <= '{fsm: bsc_pkg::SB_IDLE, mode: bsc_pkg::MP_PRESENCE,
                        present: 1'b0, perst_oe: `BSC_RST_PERST_OE,
                        refclk_en: `BSC_RST_REFCLK_EN,
                        mgmt_rst_n: `BSC_RST_MGMT_RESET_N, scl_oe: 1'b0,
                        sda_oe: 1'b0, mp_prev: `BSC_RST_PIN_LEVEL,
                        scl_prev: `BSC_RST_PIN_LEVEL, unrec: 1'b0,
                        cable_type: `BSC_RST_PIN_LEVEL, chg_pulse: 1'b0,
                        scl_level: `BSC_RST_PIN_LEVEL, sda_level: `BSC_RST_PIN_LEVEL,
                        scl_rise: 1'b0, configured: 1'b0};
      end
    end
    else
    begin
      st_q <= st_d;
    end
  end

  // ========================================================================
  // outputs
  // ========================================================================

  always_comb
  begin
    for (int i = 0; i < NUM_SB; i++)
    begin
      // every pin enable and status bit is a plain copy of a state flop; perst_n_out, mp_pin_oe and the pin data outputs are tied low
      pin_out[i].mgmt_bus_reset_n = st_q.sb[i].mgmt_rst_n;
      pin_out[i].perst_n_out = 1'b0;
      pin_out[i].perst_n_oe = st_q.sb[i].perst_oe;
      pin_out[i].refclk_en = st_q.sb[i].refclk_en;
      // the device never pulls the multipurpose pin; it only listens
      pin_out[i].mp_pin_out = 1'b0;
      pin_out[i].mp_pin_oe = 1'b0;
      pin_out[i].mgmt_bus_clock_out = 1'b0;
      pin_out[i].mgmt_bus_clock_oe = st_q.sb[i].scl_oe;
      pin_out[i].mgmt_bus_data_out = 1'b0;
      pin_out[i].mgmt_bus_data_oe = st_q.sb[i].sda_oe;
      status[i].unrecognised_bp = st_q.sb[i].unrec;
      status[i].sb_configured = st_q.sb[i].configured;
      status[i].drive_present = st_q.sb[i].present;
      status[i].cable_type = st_q.sb[i].cable_type;
      status[i].change_detect_n_mode = (st_q.sb[i].mode == bsc_pkg::MP_CHANGE);
      status[i].change_detect = st_q.sb[i].chg_pulse;
      status[i].mgmt_clock_level = st_q.sb[i].scl_level;
      status[i].mgmt_data_level = st_q.sb[i].sda_level;
      status[i].mgmt_clock_rise = st_q.sb[i].scl_rise;
    end
  end

endmodule
`default_nettype wire

// >>> logic/bsc_sync_filter.sv
// two-flop synchroniser followed by a stability filter for one pin
`timescale 1ns/1ns
`default_nettype none
`include "bsc_defines.svh"

module bsc_sync_filter #(
  parameter int STABLE_CYC = `BSC_DEBOUNCE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // pin
  input wire logic pin_async,
  // filtered view
  output logic level,
  output logic valid
);

  localparam int CW = $clog2(STABLE_CYC + 1);

  initial
  begin
    if (STABLE_CYC < 1)
    begin
      $error("bsc_sync_filter: STABLE_CYC must be at least 1");
    end
  end

  typedef struct packed {
    logic meta;
    logic sync;
    logic level;
    logic valid;
    logic [CW-1:0] cnt;
  } bsc_sf_state_t;

  bsc_sf_state_t st_q;
  bsc_sf_state_t st_d;

  always_comb
  begin
    st_d = st_q;
    st_d.meta = pin_async;
    st_d.sync = st_q.meta;
    // a level is taken only after it held for the whole window
    if (st_q.sync == st_q.level)
    begin
      st_d.cnt = '0;
    end
    else if (st_q.cnt == CW'(STABLE_CYC - 1))
    begin
      st_d.cnt = '0;
      st_d.level = st_q.sync;
      st_d.valid = 1'b1;
    end
    else
    begin
      st_d.cnt = st_q.cnt + CW'(1);
    end
    // a pin already at its idle level counts as settled too
    if (st_q.sync == st_q.level && st_q.cnt == '0 && !st_q.valid)
    begin
      st_d.cnt = CW'(1);
    end
    if (!st_q.valid && st_q.sync == st_q.level && st_q.cnt == CW'(STABLE_CYC - 1))
    begin
      st_d.valid = 1'b1;
    end
    else if (!st_q.valid && st_q.sync == st_q.level && st_q.cnt != '0)
    begin
      st_d.cnt = st_q.cnt + CW'(1);
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      st_q <= '{meta: `BSC_RST_PIN_LEVEL, sync: `BSC_RST_PIN_LEVEL,
                level: `BSC_RST_PIN_LEVEL, valid: 1'b0, cnt: '0};
    end
    else
    begin
      st_q <= st_d;
    end
  end

  assign level = st_q.level;
  assign valid = st_q.valid;

endmodule
`default_nettype wire

// >>> tb/bsc_bp_model.sv
// backplane side model: type strap, drive presence and controller pulls
`timescale 1ns/1ns
`default_nettype none
module bsc_bp_model #(
  parameter int NUM_SB = 2
) (
  // device pins
  input wire bsc_pkg::bsc_pin_out_t [NUM_SB-1:0] pin_out,
  output wire bsc_pkg::bsc_pin_in_t [NUM_SB-1:0] pin_in,
  // scenario controls
  input wire logic [NUM_SB-1:0] type_two_wire,
  input wire logic [NUM_SB-1:0] drive_in,
  input wire logic [NUM_SB-1:0] cdet_pull,
  input wire logic [NUM_SB-1:0] data_pull,
  input wire logic [NUM_SB-1:0] link_run
);
  for (genvar i = 0; i < NUM_SB; i++)
  begin : g_sb
    logic clk_pull;
    initial
    begin
      clk_pull = 1'b0;
      forever
      begin
        wait (link_run[i] === 1'b1);
        #400;
        clk_pull = 1'b1;
        #400;
        clk_pull = 1'b0;
      end
    end
    assign pin_in[i] = '{type_two_wire[i],
      !(pin_out[i].mp_pin_oe || drive_in[i] || cdet_pull[i]),
      !(pin_out[i].mgmt_bus_clock_oe || clk_pull),
      !(pin_out[i].mgmt_bus_data_oe || data_pull[i])};
  end
endmodule
`default_nettype wire

// >>> tb/bsc_sideband_chk.sv
// port checker for the backplane sideband control block
`timescale 1ns/1ns
`default_nettype none
module bsc_sideband_chk #(
  parameter int NUM_CONN = 4,
  parameter int DEBOUNCE_CYC = 100,
  localparam int NUM_SB = NUM_CONN * 2
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // pins and firmware side
  input wire bsc_pkg::bsc_pin_in_t [NUM_SB-1:0] pin_in,
  input wire bsc_pkg::bsc_pin_out_t [NUM_SB-1:0] pin_out,
  input wire bsc_pkg::bsc_ctrl_t [NUM_SB-1:0] ctrl,
  input wire bsc_pkg::bsc_status_t [NUM_SB-1:0] status
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);
  // ==========================================================
  // per sideband relations
  for (genvar i = 0; i < NUM_SB; i++)
  begin : g_sb
    chk_mp_released: assert property (!pin_out[i].mp_pin_oe)
      else $error("multipurpose pin pulled by device");
    chk_perst_until_cfg: assert property (!pin_out[i].perst_n_oe |-> status[i].sb_configured)
      else $error("pcie reset released before detection");
    chk_refclk_cap: assert property (pin_out[i].refclk_en |->
      $past(ctrl[i].clock_routing_cap) || $past(ctrl[i].clock_routing_cap, 2))
      else $error("reference clock on without routing capability");
    chk_refclk_on: assert property (status[i].sb_configured && status[i].drive_present &&
      ctrl[i].clock_routing_cap |-> ##[0:2] pin_out[i].refclk_en)
      else $error("reference clock not enabled for present drive");
    chk_unrec_quiet: assert property (status[i].unrecognised_bp && $past(status[i].unrecognised_bp)
      |-> pin_out[i].mgmt_bus_reset_n && pin_out[i].perst_n_oe &&
      !pin_out[i].mgmt_bus_data_oe && !pin_out[i].mgmt_bus_clock_oe)
      else $error("unrecognised sideband still driven");
    chk_mreset_apply: assert property ((ctrl[i].mgmt_reset_req && ctrl[i].target_resettable &&
      !status[i].unrecognised_bp) [*3] |-> !pin_out[i].mgmt_bus_reset_n)
      else $error("management reset not applied");
    chk_mreset_cause: assert property (!pin_out[i].mgmt_bus_reset_n |->
      ($past(ctrl[i].mgmt_reset_req) && $past(ctrl[i].target_resettable)) ||
      ($past(ctrl[i].mgmt_reset_req, 2) && $past(ctrl[i].target_resettable, 2)))
      else $error("management reset without resettable request");
    chk_data_pull: assert property ((ctrl[i].mgmt_data_pull && !status[i].unrecognised_bp) [*3]
      |-> pin_out[i].mgmt_bus_data_oe && !pin_out[i].mgmt_bus_data_out)
      else $error("data line not pulled low");
    chk_cdet_pulse: assert property (status[i].change_detect |->
      status[i].change_detect_n_mode ##1 !status[i].change_detect)
      else $error("change detect outside mode or too long");
  end
endmodule

bind bsc_sideband_ctrl bsc_sideband_chk #(.NUM_CONN(NUM_CONN), .DEBOUNCE_CYC(DEBOUNCE_CYC)) u_chk (
  .ref_clk(ref_clk),
  .reset(reset),
  .pin_in(pin_in),
  .pin_out(pin_out),
  .ctrl(ctrl),
  .status(status)
);
`default_nettype wire

// >>> tb/bsc_sideband_ctrl_tb_top.sv
// self-checking bench for the backplane sideband control block
`timescale 1ns/1ns
`default_nettype none
module bsc_sideband_ctrl_tb_top;
  localparam int DEB = 4;
  logic ref_clk;
  logic reset;
  wire bsc_pkg::bsc_pin_in_t [1:0] pin_in;
  bsc_pkg::bsc_pin_out_t [1:0] pin_out;
  bsc_pkg::bsc_ctrl_t [1:0] ctrl;
  bsc_pkg::bsc_status_t [1:0] status;
  logic [1:0] type_two_wire, drive_in, cdet_pull, data_pull, link_run;
  int failures;
  int samples_checked;
  int rise_cnt;
  int cdet_cnt;

  bsc_sideband_ctrl #(.NUM_CONN(1), .DEBOUNCE_CYC(DEB)) DUT (
    .ref_clk(ref_clk),
    .reset(reset),
    .pin_in(pin_in),
    .pin_out(pin_out),
    .ctrl(ctrl),
    .status(status)
  );

  bsc_bp_model #(.NUM_SB(2)) u_bp (
    .pin_out(pin_out),
    .pin_in(pin_in),
    .type_two_wire(type_two_wire),
    .drive_in(drive_in),
    .cdet_pull(cdet_pull),
    .data_pull(data_pull),
    .link_run(link_run)
  );

  initial
  begin
    ref_clk = 1'b0;
    forever #50 ref_clk = ~ref_clk;
  end

  // pulses stand one cycle, so count them at every falling edge
  always @(negedge ref_clk)
  begin
    if (status[0].mgmt_clock_rise === 1'b1) rise_cnt++;
    if (status[0].change_detect === 1'b1) cdet_cnt++;
  end

  // ==========================================================
  // helpers
  task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      failures++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(negedge ref_clk);
  endtask

  task automatic end_sim();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // ==========================================================
  // scenarios
  task automatic t_reset();
    settle(8);
    check(pin_out[0].mgmt_bus_reset_n, 1, "mgmt reset level");
    check(pin_out[0].perst_n_oe, 1, "pcie reset not held");
    check(pin_out[0].refclk_en, 0, "refclk on in reset");
    check(status[0].cable_type, 1, "cable type in reset");
    reset = 1'b0;
  endtask

  task automatic t_detect();
    settle(DEB + 8);
    check(status[0].sb_configured, 0, "configured without drive");
    check(pin_out[0].perst_n_oe, 1, "pcie reset released early");
    check(status[1].unrecognised_bp, 1, "serial strap not reported");
    drive_in[0] = 1'b1;
    settle(DEB / 2);
    drive_in[0] = 1'b0;
    settle(DEB + 8);
    check(status[0].drive_present, 0, "short glitch accepted");
    drive_in[0] = 1'b1;
    settle(DEB + 8);
    check(pin_out[0].perst_n_oe, 0, "pcie reset held after detect");
    check(pin_out[0].refclk_en, 1, "refclk off with drive");
    check(status[0].drive_present, 1, "drive not reported");
    check(status[0].sb_configured, 1, "side a not configured");
    check(status[0].cable_type, 0, "pulled pin read as floated");
    check(status[1].sb_configured, 0, "side b configured");
    check(pin_out[1].perst_n_oe, 1, "side b pcie reset released");
  endtask

  task automatic t_cap();
    ctrl[0].clock_routing_cap = 1'b0;
    settle(3);
    check(pin_out[0].refclk_en, 0, "refclk on without capability");
    ctrl[0].clock_routing_cap = 1'b1;
    settle(3);
    check(pin_out[0].refclk_en, 1, "refclk not restored");
  endtask

  task automatic t_mgmt();
    ctrl[0].mgmt_reset_req = 1'b1;
    ctrl[1].mgmt_reset_req = 1'b1;
    ctrl[1].target_resettable = 1'b1;
    ctrl[1].mgmt_data_pull = 1'b1;
    settle(5);
    check(pin_out[0].mgmt_bus_reset_n, 1, "reset of unresettable target");
    check(pin_out[1].mgmt_bus_reset_n, 1, "reset on unrecognised side");
    check(pin_out[1].mgmt_bus_data_oe, 0, "pull on unrecognised side");
    ctrl[0].target_resettable = 1'b1;
    settle(3);
    check(pin_out[0].mgmt_bus_reset_n, 0, "mgmt reset not applied");
    ctrl[0].mgmt_reset_req = 1'b0;
    settle(3);
    check(pin_out[0].mgmt_bus_reset_n, 1, "mgmt reset not released");
  endtask

  task automatic t_link();
    ctrl[0].mgmt_data_pull = 1'b1;
    settle(6);
    check(status[0].mgmt_data_level, 0, "own data pull unseen");
    ctrl[0].mgmt_data_pull = 1'b0;
    data_pull[0] = 1'b1;
    settle(6);
    check(status[0].mgmt_data_level, 0, "far data pull unseen");
    data_pull[0] = 1'b0;
    settle(6);
    check(status[0].mgmt_data_level, 1, "data line not released");
    ctrl[0].mgmt_clock_pull = 1'b1;
    settle(6);
    check(pin_out[0].mgmt_bus_clock_oe, 1, "clock pull missing");
    check(status[0].mgmt_clock_level, 0, "own clock pull unseen");
    ctrl[0].mgmt_clock_pull = 1'b0;
    settle(6);
    check(status[0].mgmt_clock_level, 1, "clock line not released");
    rise_cnt = 0;
    #37;
    link_run[0] = 1'b1;
    #3150;
    link_run[0] = 1'b0;
    settle(12);
    check(rise_cnt[7:0], 4, "link clock rises miscounted");
  endtask

  task automatic t_cdet();
    ctrl[0].change_detect_n_capable = 1'b1;
    settle(4);
    check(status[0].change_detect_n_mode, 1, "change mode not entered");
    drive_in[0] = 1'b0;
    settle(DEB + 8);
    check(status[0].sb_configured, 1, "removal seen in change mode");
    cdet_cnt = 0;
    cdet_pull[0] = 1'b1;
    settle(DEB + 8);
    cdet_pull[0] = 1'b0;
    settle(DEB + 8);
    check(cdet_cnt[7:0], 1, "change detect pulses");
    ctrl[0].change_detect_n_capable = 1'b0;
    settle(DEB + 8);
    check(pin_out[0].perst_n_oe, 1, "pcie reset not reasserted");
    check(pin_out[0].refclk_en, 0, "refclk on after removal");
    check(status[0].cable_type, 1, "floated pin not one");
    check(status[0].drive_present, 0, "removal not reported");
    type_two_wire[1] = 1'b1;
    settle(DEB + 8);
    check(status[1].unrecognised_bp, 0, "unrecognised report kept");
    check(status[1].sb_configured, 0, "side b configured without drive");
    check(pin_out[1].mgmt_bus_reset_n, 0, "side b mgmt reset not applied");
    check(pin_out[1].mgmt_bus_data_oe, 1, "side b data pull missing");
  endtask

  initial
  begin
    #500000;
    failures++;
    end_sim();
  end

  initial
  begin
    reset = 1'b1;
    failures = 0;
    samples_checked = 0;
    rise_cnt = 0;
    cdet_cnt = 0;
    type_two_wire = 2'b01;
    drive_in = 2'b00;
    cdet_pull = 2'b00;
    data_pull = 2'b00;
    link_run = 2'b00;
    ctrl = '0;
    ctrl[0].clock_routing_cap = 1'b1;
    ctrl[1].clock_routing_cap = 1'b1;
    t_reset();
    t_detect();
    t_cap();
    t_mgmt();
    t_link();
    t_cdet();
    end_sim();
  end
endmodule
`default_nettype wire
